// >>> hdl/rlsc_pkg.sv
/*
 Package for the repeat loop and read-after-write stall control block.
 Holds constants, field positions and the packed structs passed between
 decode, address generation and this block. Assumes one core clock.
*/
package rlsc_pkg;

    localparam int          RLSC_CNT_W       = 14;
    localparam int          RLSC_RA_BIT      = 4;
    localparam logic [15:0] RLSC_W0_MAP_ADDR = 16'h0000;
    localparam logic [1:0]  RLSC_REG_CNT     = 2'h0;
    localparam logic [1:0]  RLSC_REG_STATUS  = 2'h1;
    localparam logic [13:0] RLSC_CNT_RESET   = 14'h0000;
    localparam logic [1:0]  RLSC_INTERRUPT_RETURN_INSTR_PREF = 2'h2;

    typedef enum logic [1:0] {
        RLSC_AM_DIRECT,
        RLSC_AM_INDIRECT,
        RLSC_AM_IND_MOD
    } rlsc_amode_t;

    // Destination of the executing instruction
    typedef struct packed {
        logic        valid;
        logic [3:0]  reg_n;
        rlsc_amode_t mode;
        logic [15:0] addr;
    } rlsc_dst_t;

    // Source of the prefetched instruction
    typedef struct packed {
        logic        valid;
        logic [3:0]  reg_n;
        rlsc_amode_t mode;
    } rlsc_src_t;

endpackage

// >>> hdl/rlsc_ctrl.sv
/*
 Repeat loop and read-after-write stall control.
 Assumes decode pulses exec_i once per retired instruction cycle, and the
 exception unit signals entry and return; registers on a plain strobe port.
*/
`timescale 1ns/1ns
module rlsc_ctrl (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [1:0]           reg_addr_i,
    input  wire logic [15:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [15:0]          reg_rdata_o,
    input  wire logic                 exec_i,
    input  wire logic                 repeat_i,
    input  wire logic                 repeat_use_reg_i,
    input  wire logic [13:0]          repeat_lit_i,
    input  wire logic [15:0]          repeat_reg_i,
    input  wire logic                 psv_target_i,
    input  wire rlsc_pkg::rlsc_dst_t  dst_i,
    input  wire rlsc_pkg::rlsc_src_t  src_i,
    input  wire logic                 exc_entry_i,
    input  wire logic                 interrupt_return_instr_i,
    input  wire logic [1:0]           interrupt_return_instr_cycle_i,
    input  wire logic                 restored_ra_i,
    output logic                      repeat_active_flag_o,
    output logic                      pc_hold_o,
    output logic                      fetch_inhibit_o,
    output logic                      data_inhibit_o,
    output logic                      stall_o,
    output logic                      psv_extra_o,
    output logic                      interrupt_return_instr_prefetch_o,
    output logic                      stacked_ra_o
);

    logic [13:0] repeat_loop_counter;
    logic        repeat_active_flag;
    logic        stall;
    logic        hazard;
    logic        skip_stall;
    logic        psv_pending;
    logic [13:0] next_count;
    logic        cnt_wr;

    function automatic logic [3:0] map_reg(input logic [15:0] addr);
        map_reg = addr[4:1];
    endfunction

    function automatic logic uses_ea(input rlsc_pkg::rlsc_amode_t m);
        uses_ea = (m != rlsc_pkg::RLSC_AM_DIRECT);
    endfunction

    assign cnt_wr = reg_wr_i && (reg_addr_i == rlsc_pkg::RLSC_REG_CNT);
    assign next_count = repeat_use_reg_i ? repeat_reg_i[13:0] : repeat_lit_i;

    // Hazard: destination really changes the register used by the next address calc
    always_comb begin
        hazard = 1'b0;
        if (dst_i.valid && src_i.valid && uses_ea(src_i.mode)) begin
            if (dst_i.mode == rlsc_pkg::RLSC_AM_DIRECT
                    && dst_i.reg_n == src_i.reg_n) begin
                hazard = 1'b1;
            end
            if (dst_i.mode == rlsc_pkg::RLSC_AM_IND_MOD
                    && dst_i.reg_n == src_i.reg_n) begin
                hazard = 1'b1;
            end
            if (dst_i.mode != rlsc_pkg::RLSC_AM_DIRECT
                    && dst_i.addr[15:5] == 11'h000 && !dst_i.addr[0]
                    && map_reg(dst_i.addr) == src_i.reg_n) begin
                hazard = 1'b1;
            end
        end
    end

    // Stall sequencing, one cycle in front of the prefetched instruction
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stall <= 1'b0;
        end else if (stall) begin
            stall <= 1'b0;
        end else if (exec_i && hazard && !exc_entry_i && !skip_stall) begin
            stall <= 1'b1;
        end
    end

    // Exception between the pair hides the stall; it runs after return without it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            skip_stall <= 1'b0;
        end else if (exc_entry_i) begin
            skip_stall <= 1'b1;
        end else if (exec_i) begin
            skip_stall <= 1'b0;
        end
    end

    // Counter, loaded by repeat, decremented per iteration, software writable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            repeat_loop_counter <= rlsc_pkg::RLSC_CNT_RESET;
        end else if (cnt_wr) begin
            repeat_loop_counter <= reg_wdata_i[13:0];
        end else if (exec_i && repeat_i) begin
            repeat_loop_counter <= next_count;
        end else if (exec_i && !stall && repeat_active_flag
                     && repeat_loop_counter != 14'h0000) begin
            repeat_loop_counter <= repeat_loop_counter - 14'h0001;
        end
    end

    // Active flag: hardware-only; status writes never reach it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            repeat_active_flag <= 1'b0;
        end else if (exc_entry_i) begin
            repeat_active_flag <= 1'b0;
        end else if (interrupt_return_instr_i && interrupt_return_instr_cycle_i == rlsc_pkg::RLSC_INTERRUPT_RETURN_INSTR_PREF) begin
            repeat_active_flag <= restored_ra_i
                && (repeat_loop_counter != 14'h0000);
        end else if (exec_i && repeat_i) begin
            repeat_active_flag <= (next_count != 14'h0000);
        end else if (exec_i && !stall && repeat_active_flag
                     && (repeat_loop_counter <= 14'h0001)) begin
            repeat_active_flag <= 1'b0;
        end else if (repeat_active_flag && repeat_loop_counter == 14'h0000) begin
            repeat_active_flag <= 1'b0;
        end
    end

    // Flag pushed as part of the low status byte, taken before the clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stacked_ra_o <= 1'b0;
        end else if (exc_entry_i) begin
            stacked_ra_o <= repeat_active_flag;
        end
    end

    // Program-space target needs one extra cycle after an exception return that restores an active repeat
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            psv_pending <= 1'b0;
        end else if (interrupt_return_instr_i && interrupt_return_instr_cycle_i == rlsc_pkg::RLSC_INTERRUPT_RETURN_INSTR_PREF) begin
            psv_pending <= restored_ra_i && psv_target_i;
        end else if (exec_i) begin
            psv_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                rlsc_pkg::RLSC_REG_CNT:    reg_rdata_o <= {2'h0, repeat_loop_counter};
                rlsc_pkg::RLSC_REG_STATUS: reg_rdata_o <=
                    {11'h000, repeat_active_flag, 4'h0};
                default:                   reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    // Handshake-style controls may be combinational
    assign repeat_active_flag_o = repeat_active_flag;
    assign stall_o              = stall;
    assign pc_hold_o            = repeat_active_flag || stall;
    assign fetch_inhibit_o      = repeat_active_flag || stall;
    assign data_inhibit_o       = stall;
    assign psv_extra_o          = psv_pending && psv_target_i;
    assign interrupt_return_instr_prefetch_o    = interrupt_return_instr_i
        && interrupt_return_instr_cycle_i == rlsc_pkg::RLSC_INTERRUPT_RETURN_INSTR_PREF;

endmodule

// >>> tb/rlsc_ctrl_chk.sv
/* Checker for the repeat loop and stall control block.
   Assumes it is bound to rlsc_ctrl and sees only its ports. */
`timescale 1ns/1ns
module rlsc_ctrl_chk (
    input wire logic                clk_i, rst_i, reg_wr_i, reg_rd_i, exec_i, repeat_i,
    input wire logic                repeat_use_reg_i, exc_entry_i, interrupt_return_instr_i,
    input wire logic [1:0]          reg_addr_i, interrupt_return_instr_cycle_i,
    input wire logic [13:0]         repeat_lit_i,
    input wire logic [15:0]         repeat_reg_i, reg_rdata_o,
    input wire rlsc_pkg::rlsc_dst_t dst_i,
    input wire rlsc_pkg::rlsc_src_t src_i,
    input wire logic                repeat_active_flag_o, pc_hold_o, fetch_inhibit_o,
    input wire logic                data_inhibit_o, stall_o, interrupt_return_instr_prefetch_o, stacked_ra_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [13:0] cnt = repeat_use_reg_i ? repeat_reg_i[13:0] : repeat_lit_i;
    // Mapped-location case only for plain indirect writes; other modes stay ambiguous
    wire haz = dst_i.valid && src_i.valid && src_i.mode != rlsc_pkg::RLSC_AM_DIRECT
        && ((dst_i.reg_n == src_i.reg_n && dst_i.mode != rlsc_pkg::RLSC_AM_INDIRECT)
        || (dst_i.mode == rlsc_pkg::RLSC_AM_INDIRECT && dst_i.addr == {11'h000, src_i.reg_n, 1'b0}));
    ra_set_a: assert property (exec_i && repeat_i && cnt != 0 && !reg_wr_i && !exc_entry_i
        |=> repeat_active_flag_o && pc_hold_o) else $error("flag not set by repeat");
    ra_noop_a: assert property (exec_i && repeat_i && cnt == 0 && !repeat_active_flag_o
        && !exc_entry_i |=> !repeat_active_flag_o) else $error("zero count set flag");
    ra_readonly_a: assert property (reg_wr_i && reg_addr_i == rlsc_pkg::RLSC_REG_STATUS && !exec_i
        && !exc_entry_i && !interrupt_return_instr_i |=> $stable(repeat_active_flag_o)) else $error("flag written");
    loop_hold_a: assert property (repeat_active_flag_o |-> pc_hold_o && fetch_inhibit_o)
        else $error("fetch during repeat");
    stall_haz_a: assert property (exec_i && haz && !stall_o && !exc_entry_i |=> stall_o)
        else $error("missing stall");
    stall_none_a: assert property (exec_i && (!src_i.valid || src_i.mode == rlsc_pkg::RLSC_AM_DIRECT)
        |=> !stall_o) else $error("needless stall");
    stall_one_a: assert property (stall_o |=> !stall_o) else $error("stall too long");
    stall_inh_a: assert property (stall_o |-> data_inhibit_o && fetch_inhibit_o && pc_hold_o)
        else $error("stall lets access through");
    exc_push_a: assert property (exc_entry_i |=> !repeat_active_flag_o
        && stacked_ra_o == $past(repeat_active_flag_o)) else $error("flag not stacked");
    ret_pref_a: assert property (interrupt_return_instr_prefetch_o == (interrupt_return_instr_i
        && interrupt_return_instr_cycle_i == rlsc_pkg::RLSC_INTERRUPT_RETURN_INSTR_PREF)) else $error("bad prefetch cycle");
    rd_flag_a: assert property (reg_rd_i && reg_addr_i == rlsc_pkg::RLSC_REG_STATUS
        |=> reg_rdata_o[4] == $past(repeat_active_flag_o)) else $error("status read wrong");
endmodule
bind rlsc_ctrl rlsc_ctrl_chk u_chk (.*);

// >>> tb/tb.sv
/* Self-checking bench for rlsc_ctrl: loops, interrupts, hazards.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ns
module tb;
    logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, exec_i = 0, repeat_i = 0;
    logic repeat_use_reg_i = 0, psv_target_i = 0, exc_entry_i = 0, interrupt_return_instr_i = 0, restored_ra_i = 0;
    logic [1:0] reg_addr_i = 0, interrupt_return_instr_cycle_i = 0;
    logic [13:0] repeat_lit_i = 0;
    logic [15:0] reg_wdata_i = 0, repeat_reg_i = 0, reg_rdata_o;
    rlsc_pkg::rlsc_dst_t dst_i = '0;
    rlsc_pkg::rlsc_src_t src_i = '0;
    logic repeat_active_flag_o, pc_hold_o, fetch_inhibit_o, data_inhibit_o, stall_o;
    logic psv_extra_o, interrupt_return_instr_prefetch_o, stacked_ra_o;
    int bad_count = 0, n_tests = 0;
    rlsc_ctrl u_rlsc_ctrl (.*);
    always #20 clk_i = ~clk_i;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        reg_addr_i <= a; reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic ex(input logic r);
        repeat_i <= r; exec_i <= 1'b1; psv_target_i <= 1'($urandom);
        @(posedge clk_i);
        exec_i <= 1'b0; repeat_i <= 1'b0;
        #1;
    endtask
    function automatic logic haz(rlsc_pkg::rlsc_dst_t d, rlsc_pkg::rlsc_src_t s);
        return d.valid && s.valid && s.mode != rlsc_pkg::RLSC_AM_DIRECT
            && ((d.reg_n == s.reg_n && d.mode != rlsc_pkg::RLSC_AM_INDIRECT)
            || (d.mode == rlsc_pkg::RLSC_AM_INDIRECT && d.addr == {11'h000, s.reg_n, 1'b0}));
    endfunction
    initial begin
        #2400000 bad_count++;
        wrap_up();
    end
    initial begin
        int n, k, m;
        logic [15:0] d;
        rlsc_pkg::rlsc_dst_t dv;
        rlsc_pkg::rlsc_src_t sv;
        void'($urandom(23));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 3; a++) begin
            rd(2'(a), d);
            chk(d, 16'h0000);
        end
        // Zero count first, full 14-bit count last
        for (int i = 0; i < 6; i++) begin
            n = (i == 0) ? 0 : (i == 5) ? 16383 : $urandom_range(1, 6);
            repeat_use_reg_i <= i[0];
            repeat_lit_i <= i[0] ? 14'($urandom) : 14'(n);
            repeat_reg_i <= i[0] ? {2'h3, 14'(n)} : 16'($urandom);
            ex(1'b1);
            chk(repeat_active_flag_o, 16'(n != 0));
            chk(pc_hold_o, 16'(n != 0));
            rd(2'h0, d);
            chk(d, 16'(n));
            wr(2'h1, (n != 0) ? 16'h0000 : 16'hFFFF);
            rd(2'h1, d);
            chk(d[4], 16'(n != 0));
            for (k = 0; repeat_active_flag_o === 1'b1 && k < 20000; k++) ex(1'b0);
            chk(16'(k), 16'(n));
            chk(fetch_inhibit_o, 16'h0000);
        end
        for (int j = 0; j < 2; j++) begin
            repeat_use_reg_i <= 1'b0; repeat_lit_i <= 14'h0005;
            ex(1'b1);
            ex(1'b0);
            exc_entry_i <= 1'b1;
            @(posedge clk_i);
            exc_entry_i <= 1'b0;
            #1 chk({repeat_active_flag_o, stacked_ra_o}, 16'h0001);
            wr(2'h0, j ? 16'h0003 : 16'h0000);
            interrupt_return_instr_i <= 1'b1; restored_ra_i <= 1'b1;
            for (int c = 0; c < 3; c++) begin
                interrupt_return_instr_cycle_i <= 2'(c);
                #1 chk(interrupt_return_instr_prefetch_o, 16'(c == 2));
                @(posedge clk_i);
            end
            interrupt_return_instr_i <= 1'b0; restored_ra_i <= 1'b0;
            #1 chk(repeat_active_flag_o, 16'(j));
            chk(psv_extra_o, 16'(psv_target_i));
            for (k = 0; repeat_active_flag_o === 1'b1 && k < 20; k++) ex(1'b0);
            chk(16'(k), j ? 16'h0003 : 16'h0000);
        end
        for (int i = 0; i < 60; i++) begin
            m = $urandom_range(0, 2);
            dv = {1'($urandom_range(0, 7) != 0), 4'($urandom_range(0, 3)), 2'(m),
                  (m == 1) ? 16'({$urandom_range(0, 4), 1'b0}) : 16'h1000};
            sv = {1'($urandom_range(0, 7) != 0), 4'($urandom_range(0, 3)), 2'($urandom_range(0, 2))};
            dst_i <= dv; src_i <= sv;
            ex(1'b0);
            chk({stall_o, data_inhibit_o, fetch_inhibit_o}, {13'h0, {3{haz(dv, sv)}}});
            dst_i <= '0; src_i <= '0;
            @(posedge clk_i);
            #1 chk(stall_o, 16'h0000);
        end
        wrap_up();
    end
endmodule
